// ---- hdl/cpl_pkg.sv ----
package cpl_pkg;

    localparam int DATA_W       = 8;
    localparam int COLOR_W      = 24;
    localparam int LUT_DEPTH    = 256;
    localparam int OVL_COUNT    = 3;
    localparam int PIPE_LATENCY = 2;
    localparam int BUF_DEPTH    = 2;

    // channel positions inside a 24-bit colour word
    localparam int RED_LSB = 16;
    localparam int GRN_LSB = 8;
    localparam int BLU_LSB = 0;

    // command select codes
    localparam logic [1:0] CMD_PTR_LO = 2'h0;
    localparam logic [1:0] CMD_LUT    = 2'h1;
    localparam logic [1:0] CMD_PTR_HI = 2'h2;
    localparam logic [1:0] CMD_OVL    = 2'h3;

    // colour phase codes
    localparam logic [1:0] PH_RED   = 2'h0;
    localparam logic [1:0] PH_GREEN = 2'h1;
    localparam logic [1:0] PH_BLUE  = 2'h2;

    localparam logic [1:0] OVL_NONE   = 2'h0;
    localparam logic [7:0] BLACK_CODE = 8'h00;
    localparam logic [7:0] PTR_STEP   = 8'h01;
    localparam logic [7:0] PTR_RESET  = 8'h00;

    // host pin vector layout
    localparam int          PIN_W       = 13;
    localparam int          PIN_D_LSB   = 0;
    localparam int          PIN_CS      = 8;
    localparam int          PIN_WR      = 9;
    localparam int          PIN_RD      = 10;
    localparam int          PIN_CMD_LSB = 11;
    localparam logic [12:0] PIN_IDLE    = 13'h0700;

    // output stream word layout
    localparam int STREAM_W   = 27;
    localparam int ST_SYNC    = 0;
    localparam int ST_BLANK   = 1;
    localparam int ST_SETUP   = 2;
    localparam int ST_BLU_LSB = 3;
    localparam int ST_GRN_LSB = 11;
    localparam int ST_RED_LSB = 19;

    typedef logic [1:0] cpl_phase_t;

    function automatic logic [7:0] color_byte(input logic [23:0] word, input cpl_phase_t ph);
        color_byte = (ph == PH_RED)   ? word[RED_LSB +: DATA_W] :
                     (ph == PH_GREEN) ? word[GRN_LSB +: DATA_W] : word[BLU_LSB +: DATA_W];
    endfunction

    function automatic cpl_phase_t phase_next(input cpl_phase_t ph);
        phase_next = (ph == PH_RED) ? PH_GREEN : (ph == PH_GREEN) ? PH_BLUE : PH_RED;
    endfunction

    function automatic logic is_ptr_cmd(input logic [1:0] cmd);
        is_ptr_cmd = (cmd == CMD_PTR_LO) || (cmd == CMD_PTR_HI);
    endfunction

endpackage

// ---- hdl/cpl_stream_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface cpl_stream_if #(
    parameter int W = cpl_pkg::STREAM_W
) (
    input wire logic clk,
    input wire logic rst_n
);
    logic [W-1:0] in_data;
    logic         in_valid;
    logic         in_ready;
    logic [W-1:0] out_data;
    logic         out_valid;
    logic         out_ready;

    modport buffer (
        input  clk, rst_n, in_data, in_valid, out_ready,
        output in_ready, out_data, out_valid
    );
    modport user (
        input  in_ready, out_data, out_valid,
        output in_data, in_valid, out_ready
    );
endinterface
`default_nettype wire

// ---- hdl/cpl_skid_buffer.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpl_skid_buffer #(
    parameter int W = cpl_pkg::STREAM_W
) (
    cpl_stream_if.buffer sif
);
    logic [W-1:0] head_r;
    logic [W-1:0] tail_r;
    logic [1:0]   count_r;
    logic [1:0]   count_nxt;
    logic         ready_r;
    logic         valid_r;
    wire          push = sif.in_valid & ready_r;
    wire          pop  = valid_r & sif.out_ready;

    assign count_nxt = (push && !pop) ? 2'(count_r + 2'h1) :
                       (pop && !push) ? 2'(count_r - 2'h1) : count_r;
    assign sif.in_ready  = ready_r;
    assign sif.out_valid = valid_r;
    assign sif.out_data  = head_r;

    always_ff @(posedge sif.clk or negedge sif.rst_n)
    begin
        if (!sif.rst_n)
        begin
            count_r <= 2'h0;
            ready_r <= 1'b1;
            valid_r <= 1'b0;
        end
        else
        begin
            count_r <= count_nxt;
            ready_r <= (count_nxt != 2'(cpl_pkg::BUF_DEPTH));
            valid_r <= (count_nxt != 2'h0);
        end
    end

    // head always holds the oldest word
    always_ff @(posedge sif.clk)
    begin
        if (pop && (count_r == 2'h2))
            head_r <= tail_r;
        else if (push && ((count_r == 2'h0) || (pop && count_r == 2'h1)))
            head_r <= sif.in_data;
        if (push && ((count_r == 2'h1 && !pop) || count_r == 2'h2))
            tail_r <= sif.in_data;
    end
endmodule
`default_nettype wire

// ---- hdl/cpl_lookup_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpl_lookup_top #(
    parameter int LUT_DEPTH = cpl_pkg::LUT_DEPTH
) (
    input  wire logic       CLK_SYS,
    input  wire logic       RST_N,
    input  wire logic       CS_N,
    input  wire logic       WR_N,
    input  wire logic       RD_N,
    input  wire logic [1:0] COMMAND_SELECT,
    input  wire logic [7:0] HOST_DATA_BUS_IN,
    output var  logic [7:0] HOST_DATA_BUS_OUT,
    output var  logic       HOST_DATA_BUS_OE,
    input  wire logic [7:0] PIXEL_INDEX,
    input  wire logic [1:0] OVERLAY_SELECT,
    input  wire logic       SYNC_N,
    input  wire logic       BLANK_N,
    input  wire logic       PIXEL_VALID,
    output logic            PIXEL_READY,
    output logic [7:0]      RED_CODE,
    output logic [7:0]      GREEN_CODE,
    output logic [7:0]      BLUE_CODE,
    output logic            SETUP_ON,
    output logic            BLANK_LEVEL,
    output logic            GREEN_TIMING_CURRENT,
    output logic            CODE_VALID,
    input  wire logic       CODE_READY
);
    localparam int DW = cpl_pkg::DATA_W;
    localparam int CW = cpl_pkg::COLOR_W;
    localparam int PW = cpl_pkg::PIN_W;

    // host pin synchroniser and filter
    logic [PW-1:0] sync1_r;
    logic [PW-1:0] sync2_r;
    logic [PW-1:0] sync3_r;
    logic [PW-1:0] pins_r;
    wire  [PW-1:0] pin_vec;
    wire  [PW-1:0] agree;
    wire  [PW-1:0] pins_nxt;

    // host access tracking
    logic          wr_act_r;
    logic          rd_act_r;
    logic [1:0]    wcmd_r;
    logic [1:0]    rcmd_r;
    logic [DW-1:0] wdata_r;
    logic [DW-1:0] red_r;
    logic [DW-1:0] grn_r;
    logic [DW-1:0] ptr_r;
    logic [DW-1:0] ptr_nxt;
    cpl_pkg::cpl_phase_t phase_r;
    cpl_pkg::cpl_phase_t phase_nxt;
    logic [DW-1:0] dout_r;
    logic          doe_r;
    logic [CW-1:0] host_word_r;

    // storage
    logic [CW-1:0] lut_mem [LUT_DEPTH];
    logic [CW-1:0] ovl_mem [1:cpl_pkg::OVL_COUNT];

    // pixel pipeline
    logic          s1_valid_r;
    logic [DW-1:0] s1_idx_r;
    logic [1:0]    s1_ovl_r;
    logic          s1_sync_r;
    logic          s1_blank_r;
    logic          s2_valid_r;
    logic [CW-1:0] s2_word_r;
    logic          s2_sync_r;
    logic          s2_blank_r;

    cpl_stream_if #(.W(cpl_pkg::STREAM_W)) sif (
        .clk   (CLK_SYS),
        .rst_n (RST_N)
    );

    cpl_skid_buffer #(.W(cpl_pkg::STREAM_W)) u_buf (
        .sif (sif.buffer)
    );

    // ---------------- host side ----------------
    assign pin_vec = {COMMAND_SELECT, RD_N, WR_N, CS_N, HOST_DATA_BUS_IN};
    assign agree    = ~(sync2_r ^ sync3_r);
    assign pins_nxt = (agree & sync3_r) | (~agree & pins_r);

    // three-stage synchroniser, change taken on agreement
    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            sync1_r <= cpl_pkg::PIN_IDLE;
            sync2_r <= cpl_pkg::PIN_IDLE;
            sync3_r <= cpl_pkg::PIN_IDLE;
            pins_r  <= cpl_pkg::PIN_IDLE;
        end
        else
        begin
            sync1_r <= pin_vec;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            pins_r  <= pins_nxt;
        end
    end

    wire          cs_act   = ~pins_r[cpl_pkg::PIN_CS];
    wire [1:0]    pin_cmd  = pins_r[cpl_pkg::PIN_CMD_LSB +: 2];
    wire [DW-1:0] pin_data = pins_r[cpl_pkg::PIN_D_LSB +: DW];

    // both strobes low is undefined; such a cycle is taken as neither
    // write active while select and write are both low
    wire wr_act = cs_act & ~pins_r[cpl_pkg::PIN_WR] & pins_r[cpl_pkg::PIN_RD];
    // read active while select and read are both low
    wire rd_act = cs_act & ~pins_r[cpl_pkg::PIN_RD] & pins_r[cpl_pkg::PIN_WR];

    // write completes on the first rising strobe
    wire wr_end   = wr_act_r & ~wr_act;
    wire rd_start = rd_act & ~rd_act_r;
    wire rd_end   = rd_act_r & ~rd_act;

    wire wr_is_ptr = cpl_pkg::is_ptr_cmd(wcmd_r);
    wire rd_is_ptr = cpl_pkg::is_ptr_cmd(rcmd_r);
    wire wr_is_lut = (wcmd_r == cpl_pkg::CMD_LUT);
    wire wr_is_ovl = (wcmd_r == cpl_pkg::CMD_OVL);
    wire rd_is_lut = (pin_cmd == cpl_pkg::CMD_LUT);

    // overlay index from low pointer bits only
    wire [1:0] ovl_idx   = ptr_r[1:0];
    wire       ovl_valid = (ovl_idx != cpl_pkg::OVL_NONE);

    wire ptr_load  = wr_end & wr_is_ptr;
    // phase steps on every table or overlay data access
    wire data_step = (wr_end & ~wr_is_ptr) | (rd_end & ~rd_is_ptr);
    wire blue_done = data_step & (phase_r == cpl_pkg::PH_BLUE);

    // blue write commits the assembled word
    wire [CW-1:0] wr_word = {red_r, grn_r, wdata_r};
    wire blue_wr = wr_end & (phase_r == cpl_pkg::PH_BLUE);
    wire lut_we  = blue_wr & wr_is_lut;
    wire ovl_we  = blue_wr & wr_is_ovl & ovl_valid;

    // phase cleared by pointer write only
    assign phase_nxt = ptr_load  ? cpl_pkg::PH_RED :
                       data_step ? cpl_pkg::phase_next(phase_r) : phase_r;
    // eight-bit add wraps FF to 00
    assign ptr_nxt = ptr_load  ? wdata_r :
                     blue_done ? DW'(ptr_r + cpl_pkg::PTR_STEP) : ptr_r;

    wire [CW-1:0] ovl_word  = ovl_valid ? ovl_mem[ovl_idx] : '0;
    wire [CW-1:0] rd_word   = rd_is_lut ? host_word_r : ovl_word;
    wire [DW-1:0] rd_byte   = cpl_pkg::color_byte(rd_word, phase_r);
    // pointer readable; phase never placed on the bus
    wire [DW-1:0] dout_nxt  = rd_start ? (cpl_pkg::is_ptr_cmd(pin_cmd) ? ptr_r : rd_byte) : dout_r;

    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            wr_act_r <= 1'b0;
            rd_act_r <= 1'b0;
            wcmd_r   <= cpl_pkg::CMD_PTR_LO;
            rcmd_r   <= cpl_pkg::CMD_PTR_LO;
            wdata_r  <= cpl_pkg::BLACK_CODE;
        end
        else
        begin
            wr_act_r <= wr_act;
            rd_act_r <= rd_act;
            if (wr_act)
            begin
                wcmd_r  <= pin_cmd;
                wdata_r <= pin_data;
            end
            if (rd_start)
                rcmd_r <= pin_cmd;
        end
    end

    // pointer and phase have defined reset state
    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ptr_r   <= cpl_pkg::PTR_RESET;
            phase_r <= cpl_pkg::PH_RED;
        end
        else
        begin
            ptr_r   <= ptr_nxt;
            phase_r <= phase_nxt;
        end
    end

    // bus driven only during a read
    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            dout_r <= cpl_pkg::BLACK_CODE;
            doe_r  <= 1'b0;
        end
        else
        begin
            dout_r <= dout_nxt;
            doe_r  <= rd_act;
        end
    end

    // red and green bytes staged until blue arrives
    always_ff @(posedge CLK_SYS)
    begin
        if (wr_end && !wr_is_ptr && phase_r == cpl_pkg::PH_RED)
            red_r <= wdata_r;
        if (wr_end && !wr_is_ptr && phase_r == cpl_pkg::PH_GREEN)
            grn_r <= wdata_r;
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (lut_we)
            lut_mem[ptr_r] <= wr_word;
        if (ovl_we)
            ovl_mem[ovl_idx] <= wr_word;
        host_word_r <= lut_mem[ptr_r];
    end

    assign HOST_DATA_BUS_OUT = dout_r;
    assign HOST_DATA_BUS_OE  = doe_r;

    // ---------------- pixel side ----------------
    // whole pipeline holds while the buffer is full
    wire adv = sif.in_ready;

    // pixel, overlay, sync and blank captured on one edge
    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            s1_valid_r <= 1'b0;
            s1_idx_r   <= cpl_pkg::BLACK_CODE;
            s1_ovl_r   <= cpl_pkg::OVL_NONE;
            s1_sync_r  <= 1'b1;
            s1_blank_r <= 1'b1;
        end
        else if (adv)
        begin
            s1_valid_r <= PIXEL_VALID;
            s1_idx_r   <= PIXEL_INDEX;
            s1_ovl_r   <= OVERLAY_SELECT;
            s1_sync_r  <= SYNC_N;
            s1_blank_r <= BLANK_N;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            s2_valid_r <= 1'b0;
            s2_sync_r  <= 1'b1;
            s2_blank_r <= 1'b1;
        end
        else if (adv)
        begin
            s2_valid_r <= s1_valid_r;
            s2_sync_r  <= s1_sync_r;
            s2_blank_r <= s1_blank_r;
        end
    end

    // overlay code 00 uses the table, others ignore the index
    wire [CW-1:0] pix_word = (s1_ovl_r == cpl_pkg::OVL_NONE) ? lut_mem[s1_idx_r] : ovl_mem[s1_ovl_r];

    // selected colour held for the converters
    always_ff @(posedge CLK_SYS)
    begin
        if (adv)
            s2_word_r <= pix_word;
    end

    wire blanked = ~s2_blank_r;
    wire to_black = blanked | cs_act;

    // one channel code, black when hidden
    function automatic logic [DW-1:0] chan_code(input logic [CW-1:0] word, input int lsb, input logic black);
        chan_code = black ? cpl_pkg::BLACK_CODE : word[lsb +: DW];
    endfunction

    wire [DW-1:0] red_code = chan_code(s2_word_r, cpl_pkg::RED_LSB, to_black);
    wire [DW-1:0] grn_code = chan_code(s2_word_r, cpl_pkg::GRN_LSB, to_black);
    wire [DW-1:0] blu_code = chan_code(s2_word_r, cpl_pkg::BLU_LSB, to_black);

    // sync only gates its own current
    assign sif.in_data  = {red_code, grn_code, blu_code, ~blanked, blanked, s2_sync_r};
    assign sif.in_valid = s2_valid_r;
    assign sif.out_ready = CODE_READY;

    assign PIXEL_READY          = sif.in_ready;
    assign CODE_VALID           = sif.out_valid;
    assign RED_CODE             = sif.out_data[cpl_pkg::ST_RED_LSB +: DW];
    assign GREEN_CODE           = sif.out_data[cpl_pkg::ST_GRN_LSB +: DW];
    assign BLUE_CODE            = sif.out_data[cpl_pkg::ST_BLU_LSB +: DW];
    assign SETUP_ON             = sif.out_data[cpl_pkg::ST_SETUP];
    assign BLANK_LEVEL          = sif.out_data[cpl_pkg::ST_BLANK];
    assign GREEN_TIMING_CURRENT = sif.out_data[cpl_pkg::ST_SYNC];
endmodule
`default_nettype wire

// ---- tb/cpl_lookup_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpl_lookup_monitor (
    input wire logic       CLK_SYS,
    input wire logic       RST_N,
    input wire logic       CS_N,
    input wire logic       RD_N,
    input wire logic       HOST_DATA_BUS_OE,
    input wire logic       PIXEL_VALID,
    input wire logic       PIXEL_READY,
    input wire logic [7:0] RED_CODE,
    input wire logic [7:0] GREEN_CODE,
    input wire logic [7:0] BLUE_CODE,
    input wire logic       SETUP_ON,
    input wire logic       BLANK_LEVEL,
    input wire logic       GREEN_TIMING_CURRENT,
    input wire logic       CODE_VALID,
    input wire logic       CODE_READY
);
    logic [23:0] rgb;
    assign rgb = {RED_CODE, GREEN_CODE, BLUE_CODE};
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    property p_oe_cause;
        $rose(HOST_DATA_BUS_OE) |-> !$past(CS_N, 3) && !$past(RD_N, 3);
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("bus driven without a read");
    property p_oe_release;
        CS_N [*8] |-> !HOST_DATA_BUS_OE;
    endproperty
    a_oe_release: assert property (p_oe_release) else $error("bus still driven");
    property p_cs_black;
        (!CS_N && CODE_READY) [*8] ##0 CODE_VALID |-> rgb == 24'h000000;
    endproperty
    a_cs_black: assert property (p_cs_black) else $error("colour while selected");
    property p_blank;
        CODE_VALID && BLANK_LEVEL |-> rgb == 24'h000000 && !SETUP_ON;
    endproperty
    a_blank: assert property (p_blank) else $error("colour while blanked");
    property p_setup;
        CODE_VALID |-> SETUP_ON != BLANK_LEVEL;
    endproperty
    a_setup: assert property (p_setup) else $error("setup offset wrong");
    property p_hold;
        CODE_VALID && !CODE_READY |=> CODE_VALID && $stable(rgb)
            && $stable({SETUP_ON, BLANK_LEVEL, GREEN_TIMING_CURRENT});
    endproperty
    a_hold: assert property (p_hold) else $error("output word changed on stall");
    property p_latency;
        PIXEL_VALID && PIXEL_READY && CODE_READY |-> ##[1:4] CODE_VALID;
    endproperty
    a_latency: assert property (p_latency) else $error("pixel word not delivered");
    property p_full;
        !PIXEL_READY |-> CODE_VALID && !$past(CODE_READY);
    endproperty
    a_full: assert property (p_full) else $error("buffer full without stall");
    c_read: cover property ($rose(HOST_DATA_BUS_OE));
    c_stall: cover property (!PIXEL_READY);
    c_blank: cover property (CODE_VALID && BLANK_LEVEL);
endmodule
bind cpl_lookup_top cpl_lookup_monitor u_mon (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .CS_N(CS_N), .RD_N(RD_N),
    .HOST_DATA_BUS_OE(HOST_DATA_BUS_OE), .PIXEL_VALID(PIXEL_VALID), .PIXEL_READY(PIXEL_READY),
    .RED_CODE(RED_CODE), .GREEN_CODE(GREEN_CODE), .BLUE_CODE(BLUE_CODE), .SETUP_ON(SETUP_ON),
    .BLANK_LEVEL(BLANK_LEVEL), .GREEN_TIMING_CURRENT(GREEN_TIMING_CURRENT), .CODE_VALID(CODE_VALID),
    .CODE_READY(CODE_READY));
`default_nettype wire

// ---- tb/cpl_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpl_host_model (
    input  wire logic       clk,
    output var  logic       cs_n,
    output var  logic       wr_n,
    output var  logic       rd_n,
    output var  logic [1:0] cmd,
    output wire logic [7:0] data_in,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe
);
    logic [7:0] wdata_r;
    logic       wen_r;
    assign data_in = wen_r ? wdata_r : (data_oe ? data_out : ~wdata_r);
    initial
    begin
        cs_n = 1'b1;
        wr_n = 1'b1;
        rd_n = 1'b1;
        cmd = 2'h0;
        wdata_r = 8'h00;
        wen_r = 1'b0;
    end
    task automatic access(input logic [1:0] c, input logic wr, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        cmd <= c;
        wdata_r <= d;
        wen_r <= wr;
        cs_n <= 1'b0;
        wr_n <= !wr;
        rd_n <= wr;
        repeat (8) @(posedge clk);
        q = (data_oe === 1'b1) ? data_out : 8'hXX;
        cs_n <= 1'b1;
        wr_n <= 1'b1;
        rd_n <= 1'b1;
        @(posedge clk);
        wen_r <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    task automatic hold_select(input logic on);
        @(posedge clk);
        cs_n <= !on;
    endtask
endmodule
`default_nettype wire

// ---- tb/color_palette_lookup_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module color_palette_lookup_test;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    wire  logic  cs_n;
    wire  logic  wr_n;
    wire  logic  rd_n;
    wire  logic [1:0] cmd;
    wire  logic [7:0] din;
    logic [7:0]  dout;
    logic        oe;
    logic [7:0]  pix = 8'h00;
    logic [1:0]  ovl = 2'h0;
    logic        sync_n = 1'b1;
    logic        blank_n = 1'b1;
    logic        pvalid = 1'b0;
    logic        pready;
    logic [7:0]  red;
    logic [7:0]  grn;
    logic [7:0]  blu;
    logic        setup;
    logic        blank;
    logic        gtc;
    logic        cvalid;
    logic        cready = 1'b1;
    logic [23:0] lut [256];
    logic [23:0] ovr [4];
    logic [7:0]  known [4] = '{8'hFE, 8'hFF, 8'h00, 8'h05};
    logic [26:0] expq [$];
    int          seed = 49290;
    int          bad_count = 0;
    int          total_checks = 0;

    always #10 clk_sys = ~clk_sys;

    cpl_host_model u_host (.clk(clk_sys), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .cmd(cmd),
        .data_in(din), .data_out(dout), .data_oe(oe));
    cpl_lookup_top u_dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .CS_N(cs_n), .WR_N(wr_n), .RD_N(rd_n),
        .COMMAND_SELECT(cmd), .HOST_DATA_BUS_IN(din), .HOST_DATA_BUS_OUT(dout), .HOST_DATA_BUS_OE(oe),
        .PIXEL_INDEX(pix), .OVERLAY_SELECT(ovl), .SYNC_N(sync_n), .BLANK_N(blank_n), .PIXEL_VALID(pvalid),
        .PIXEL_READY(pready), .RED_CODE(red), .GREEN_CODE(grn), .BLUE_CODE(blu), .SETUP_ON(setup),
        .BLANK_LEVEL(blank), .GREEN_TIMING_CURRENT(gtc), .CODE_VALID(cvalid), .CODE_READY(cready));

    task automatic check(input string what, input logic [26:0] exp, input logic [26:0] got);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic wr(input logic [1:0] c, input logic [7:0] d);
        logic [7:0] q;
        u_host.access(c, 1'b1, d, q);
    endtask

    task automatic rd(input logic [1:0] c, input logic [7:0] e, input string what);
        logic [7:0] q;
        u_host.access(c, 1'b0, 8'h00, q);
        check(what, {19'h0, e}, {19'h0, q});
    endtask

    task automatic wcol(input logic [1:0] c, input logic [23:0] v);
        wr(c, v[23:16]);
        wr(c, v[15:8]);
        wr(c, v[7:0]);
    endtask

    task automatic rcol(input logic [1:0] c, input logic [23:0] v);
        rd(c, v[23:16], "red byte");
        rd(c, v[15:8], "green byte");
        rd(c, v[7:0], "blue byte");
    endtask

    function automatic logic [26:0] exp_word(input logic [7:0] p, input logic [1:0] o, input logic b_n,
        input logic s_n, input logic blk);
        logic [23:0] c;
        c = (o == cpl_pkg::OVL_NONE) ? lut[p] : ovr[o];
        if (!b_n || blk)
            c = 24'h000000;
        exp_word = {c, b_n, !b_n, s_n};
    endfunction

    task automatic stream(input int n, input logic blk);
        int k;
        logic [31:0] r;
        k = 0;
        while (k < n)
        begin
            @(posedge clk_sys);
            if (pvalid && pready === 1'b1)
            begin
                expq.push_back(exp_word(pix, ovl, blank_n, sync_n, blk));
                k++;
            end
            r = $random(seed);
            // a pixel on offer stays put until taken
            if (!pvalid || pready === 1'b1)
            begin
                pix <= known[r[1:0]];
                ovl <= r[3:2];
                blank_n <= r[4];
                sync_n <= r[4] | r[5];
                pvalid <= (k < n) && (r[7:6] != 2'h0);
            end
            cready <= r[9:8] != 2'h0;
        end
        @(posedge clk_sys);
        cready <= 1'b1;
        repeat (12) @(posedge clk_sys);
        check("pending words", 27'h0, 27'(expq.size()));
    endtask

    // output words compared in order
    always @(posedge clk_sys)
    begin
        if (rst_n && cvalid === 1'b1 && cready)
        begin
            if (expq.size() == 0)
                check("unexpected word", 27'h0, 27'h7FFFFFF);
            else
                check("code word", expq.pop_front(), {red, grn, blu, setup, blank, gtc});
        end
    end

    initial
    begin
        repeat (30000) @(posedge clk_sys);
        bad_count++;
        print_verdict();
    end

    initial
    begin
        logic [23:0] v;
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        check("reset state", 27'h2, {24'h0, oe, pready, cvalid});
        rd(cpl_pkg::CMD_PTR_LO, 8'h00, "pointer after reset");
        wr(cpl_pkg::CMD_PTR_HI, 8'hFE);
        for (int i = 0; i < 3; i++)
        begin
            v = 24'($random(seed));
            lut[known[i]] = v;
            wcol(cpl_pkg::CMD_LUT, v);
        end
        rd(cpl_pkg::CMD_PTR_LO, 8'h01, "pointer after wrap");
        wr(cpl_pkg::CMD_PTR_LO, 8'h05);
        v = 24'($random(seed));
        lut[8'h05] = v;
        wr(cpl_pkg::CMD_LUT, v[23:16]);
        rd(cpl_pkg::CMD_PTR_HI, 8'h05, "pointer mid colour");
        wr(cpl_pkg::CMD_LUT, v[15:8]);
        wr(cpl_pkg::CMD_LUT, v[7:0]);
        wr(cpl_pkg::CMD_PTR_LO, 8'hFE);
        wr(cpl_pkg::CMD_LUT, 8'hA5);
        wr(cpl_pkg::CMD_PTR_HI, 8'hFE);
        for (int i = 0; i < 4; i++)
        begin
            // last known entry sits apart from the wrapped run
            if (i == 3)
                wr(cpl_pkg::CMD_PTR_LO, known[3]);
            rcol(cpl_pkg::CMD_LUT, lut[known[i]]);
        end
        rd(cpl_pkg::CMD_PTR_LO, 8'h06, "pointer after reads");
        wr(cpl_pkg::CMD_PTR_LO, 8'hFD);
        for (int i = 1; i < 4; i++)
        begin
            v = 24'($random(seed));
            ovr[i] = v;
            wcol(cpl_pkg::CMD_OVL, v);
        end
        wr(cpl_pkg::CMD_PTR_LO, 8'h41);
        for (int i = 1; i < 4; i++)
            rcol(cpl_pkg::CMD_OVL, ovr[i]);
        rcol(cpl_pkg::CMD_OVL, 24'h000000);
        rd(cpl_pkg::CMD_PTR_LO, 8'h45, "pointer after overlays");
        stream(150, 1'b0);
        u_host.hold_select(1'b1);
        repeat (8) @(posedge clk_sys);
        stream(30, 1'b1);
        u_host.hold_select(1'b0);
        repeat (8) @(posedge clk_sys);
        stream(40, 1'b0);
        print_verdict();
    end
endmodule
`default_nettype wire
